// ===== shared/sarc_defines.svh
// constants of the successive approximation conversion control
`ifndef SARC_DEFINES_SVH
`define SARC_DEFINES_SVH

// result word: 14 bits, straight binary
`define SARC_RES_W 14
`define SARC_IDX_W 4
`define SARC_MSB_IDX 4'hd
`define SARC_CODE_ZERO 14'h0000
`define SARC_CODE_MID 14'h2000
`define SARC_CODE_FULL 14'h3fff

// timing, figures in ns
`define SARC_CLK_NS 40
`define SARC_THROUGHPUT_NS 2000
`define SARC_STEP_NS 120
// least time per trial step, rounded up to whole clocks
`define SARC_STEP_CYC ((`SARC_STEP_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)
// longest whole conversion, rounded down to whole clocks
`define SARC_THROUGHPUT_CYC (`SARC_THROUGHPUT_NS / `SARC_CLK_NS)
`define SARC_CNT_W 4

`endif

// ===== shared/sarc_pkg.sv
// types of the successive approximation conversion control
package sarc_pkg;

   typedef enum logic [2:0] {
      SARC_ACQ = 3'b000,
      SARC_OPEN_GND = 3'b001,
      SARC_DISCONNECT = 3'b010,
      SARC_TRIAL = 3'b011,
      SARC_DONE = 3'b100
   } sarc_state_t;

   typedef struct packed {
      sarc_state_t state;
      logic [3:0] bit_idx;
      logic [13:0] trial;
      logic [13:0] result;
      logic done;
      logic ignored;
      logic [1:0] start_sync;
      logic start_prev;
      logic [1:0] comp_sync;
   } sarc_ctrl_t;

   typedef struct packed {
      logic [3:0] cnt;
      logic tick;
   } sarc_timer_t;

endpackage

// ===== shared/sarc_tick_if.sv
// carrier between the control and its internal conversion clock
`timescale 1ns/1ps
interface sarc_tick_if;
   logic run;
   logic tick;
   modport ctrl (output run, input tick);
   modport timer (input run, output tick);
endinterface

// ===== logic/sarc_step_timer.sv
// internal conversion clock: one tick per trial step
`timescale 1ns/1ps
`include "sarc_defines.svh"
module sarc_step_timer #(
   parameter logic [3:0] STEP_CYC = 4'(`SARC_STEP_CYC)
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // step carrier
   sarc_tick_if.timer tk
);

   sarc_pkg::sarc_timer_t st_ff;
   sarc_pkg::sarc_timer_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.tick = 1'b0;
      if (!tk.run) begin
         // hold the count at zero while run is low so no stale count leaks into the next conversion
         nxt_st.cnt = 4'h0;
      end else if (st_ff.cnt == STEP_CYC - 4'h1) begin
         nxt_st.cnt = 4'h0;
      end else begin
         nxt_st.cnt = st_ff.cnt + 4'h1;
      end
      // registered tick marks the step's last cycle
      nxt_st.tick = tk.run && (nxt_st.cnt == STEP_CYC - 4'h1);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // gated by run so a leftover tick never reaches a new conversion
   assign tk.tick = tk.run && st_ff.tick;

endmodule

// ===== logic/sarc_conversion_control.sv
// successive approximation conversion control, acquisition to result
// Contract
// (RL1) start rise: open ground switches, then disconnect
// (RL2) fourteen binary trials, msb first
// (RL3) return to acquisition unprompted after last step
// (RL4) present code and pulse conversion complete
// (RL5) steps timed by internal conversion clock
// (RL6) result is fourteen bit straight binary
// (RL7) over range saturates at all ones
// (RL8) under range saturates at all zeros
// (RL9) result belongs to this conversion's sample
// (RL10) up to 500 kSPS, powered down between
// (RL11) conversion completes regardless of start input
// (RL12) hold result register until next completion
`timescale 1ns/1ps
`include "sarc_defines.svh"
module sarc_conversion_control #(
   parameter logic [3:0] STEP_CYC = 4'(`SARC_STEP_CYC)
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // conversion trigger pin
   input wire logic convert_start,
   // analog front end
   input wire logic comp_keep,
   output logic pos_array_ground_switch,
   output logic neg_array_ground_switch,
   output logic array_sample,
   output logic [13:0] dac_trial,
   output logic analog_power_up,
   // toward serial output logic
   output logic conv_busy,
   output logic conv_done,
   output logic [13:0] result_code,
   output logic start_ignored
);

   sarc_pkg::sarc_ctrl_t st_ff;
   sarc_pkg::sarc_ctrl_t nxt_st;
   sarc_tick_if tk ();

   logic start_rise;
   logic last_step;
   logic [13:0] one_hot;
   logic [13:0] kept;

   sarc_step_timer #(
      .STEP_CYC(STEP_CYC)
   ) u_timer (
      .clk(clk),
      .sys_rst(sys_rst),
      .tk(tk)
   );

   // edge looks only at the second sync stage
   assign start_rise = st_ff.start_sync[1] && !st_ff.start_prev;
   assign last_step = (st_ff.bit_idx == 4'h0);
   assign one_hot = 14'h0001 << st_ff.bit_idx;
   // trial bit stays when the held sample sits at or above the level
   assign kept = st_ff.comp_sync[1] ? st_ff.trial
      : (st_ff.trial & ~one_hot);

   // RL5 steps paced by timer
   assign tk.run = (st_ff.state == sarc_pkg::SARC_TRIAL);

   always_comb begin
      nxt_st = st_ff;
      nxt_st.done = 1'b0;
      nxt_st.ignored = 1'b0;
      nxt_st.start_sync = {st_ff.start_sync[0], convert_start};
      nxt_st.start_prev = st_ff.start_sync[1];
      nxt_st.comp_sync = {st_ff.comp_sync[0], comp_keep};
      case (st_ff.state)
         sarc_pkg::SARC_ACQ: begin
            // RL1 rise ends acquisition
            if (start_rise) begin
               nxt_st.state = sarc_pkg::SARC_OPEN_GND;
            end
         end
         sarc_pkg::SARC_OPEN_GND: begin
            // RL1 arrays leave inputs after switches open
            nxt_st.state = sarc_pkg::SARC_DISCONNECT;
         end
         sarc_pkg::SARC_DISCONNECT: begin
            // RL2 first trial at half reference
            nxt_st.state = sarc_pkg::SARC_TRIAL;
            nxt_st.bit_idx = `SARC_MSB_IDX;
            nxt_st.trial = `SARC_CODE_MID;
         end
         sarc_pkg::SARC_TRIAL: begin
            if (tk.tick) begin
               // RL2 decide bit, move one weight down
               if (last_step) begin
                  // RL7 no carry: all kept gives all ones
                  // RL8 none kept gives all zeros
                  nxt_st.trial = kept;
                  nxt_st.state = sarc_pkg::SARC_DONE;
               end else begin
                  nxt_st.bit_idx = st_ff.bit_idx - 4'h1;
                  nxt_st.trial = kept | (one_hot >> 1);
               end
            end
         end
         sarc_pkg::SARC_DONE: begin
            // RL9 code from this sample only
            // RL6 trial word is the straight binary code
            // RL12 held until next completion
            nxt_st.result = st_ff.trial;
            // RL4 completion pulse
            nxt_st.done = 1'b1;
            // RL3 back to acquisition
            nxt_st.state = sarc_pkg::SARC_ACQ;
         end
         default: begin
            nxt_st.state = sarc_pkg::SARC_ACQ;
         end
      endcase
      // RL11 starts during conversion are ignored
      if (start_rise && (st_ff.state != sarc_pkg::SARC_ACQ)) begin
         nxt_st.ignored = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // switches closed only while acquiring
   assign pos_array_ground_switch = (st_ff.state == sarc_pkg::SARC_ACQ);
   assign neg_array_ground_switch = (st_ff.state == sarc_pkg::SARC_ACQ);
   assign array_sample = (st_ff.state == sarc_pkg::SARC_ACQ) ||
      (st_ff.state == sarc_pkg::SARC_OPEN_GND);
   assign dac_trial = (st_ff.state == sarc_pkg::SARC_TRIAL) ?
      st_ff.trial : `SARC_CODE_ZERO;
   // RL10 front end powered only while converting
   assign analog_power_up = (st_ff.state != sarc_pkg::SARC_ACQ);
   assign conv_busy = (st_ff.state != sarc_pkg::SARC_ACQ);
   assign conv_done = st_ff.done;
   assign result_code = st_ff.result;
   assign start_ignored = st_ff.ignored;

endmodule

// ===== tb/sarc_sva.sv
// checker on the conversion control ports
`timescale 1ns/1ps
module sarc_sva (
   input wire logic clk, sys_rst, conv_busy, conv_done, start_ignored,
   input wire logic array_sample, analog_power_up,
   input wire logic pos_array_ground_switch, neg_array_ground_switch,
   input wire logic [13:0] dac_trial, result_code
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   gnd_open_a: assert property (
      $rose(conv_busy) |-> array_sample && !pos_array_ground_switch
      && !neg_array_ground_switch) else $error("switches not open");
   disconnect_a: assert property (
      $rose(conv_busy) |=> !array_sample) else $error("no disconnect");
   msb_first_a: assert property (
      $rose(conv_busy) |-> ##2 dac_trial == 14'h2000)
      else $error("first trial not msb");
   conv_len_a: assert property (
      $rose(conv_busy) |-> ##45 conv_done) else $error("bad length");
   back_acq_a: assert property (
      conv_done |-> !conv_busy && pos_array_ground_switch && array_sample)
      else $error("not back in acquisition");
   done_pulse_a: assert property (
      conv_done |=> !conv_done) else $error("done too long");
   hold_res_a: assert property (
      !conv_done |-> $stable(result_code)) else $error("result moved");
   pwr_down_a: assert property (
      !conv_busy |-> !analog_power_up) else $error("power left on");
   ignore_busy_a: assert property (
      start_ignored |-> $past(conv_busy)) else $error("ignored while idle");
   cover property ($rose(conv_done));
   cover property (start_ignored);
   cover property (conv_done && result_code == 14'h3fff);
endmodule
bind sarc_conversion_control sarc_sva sarc_sva_inst (
   .clk(clk),
   .sys_rst(sys_rst),
   .conv_busy(conv_busy),
   .conv_done(conv_done),
   .start_ignored(start_ignored),
   .array_sample(array_sample),
   .analog_power_up(analog_power_up),
   .pos_array_ground_switch(pos_array_ground_switch),
   .neg_array_ground_switch(neg_array_ground_switch),
   .dac_trial(dac_trial),
   .result_code(result_code)
);

// ===== tb/sarc_cmp_model.sv
// comparator and sampling arrays of the analog front end
`timescale 1ns/1ps
module sarc_cmp_model (
   input wire logic clk, array_sample,
   input wire logic [13:0] dac_trial,
   input int vin,
   output logic comp_keep
);
   int held = 0;
   always @(posedge clk)
      if (array_sample) held <= vin;
   assign comp_keep = held >= int'(dac_trial);
endmodule

// ===== tb/sar_conversion_control_bench.sv
// bench for the conversion control
`timescale 1ns/1ps
`include "sarc_defines.svh"
module sar_conversion_control_bench;
   logic clk = 0, sys_rst = 1, convert_start = 0, comp_keep;
   logic pos_array_ground_switch, neg_array_ground_switch;
   logic array_sample, analog_power_up, conv_busy, conv_done;
   logic start_ignored;
   logic [13:0] dac_trial, result_code;
   int vin = 0, bad_count = 0, n_checks = 0;
   int lv[6] = '{0, 1, 8191, 8192, 8193, 16383};
   always #20 clk = ~clk;
   sarc_conversion_control sarc_conversion_control_inst (
      .clk(clk),
      .sys_rst(sys_rst),
      .convert_start(convert_start),
      .comp_keep(comp_keep),
      .pos_array_ground_switch(pos_array_ground_switch),
      .neg_array_ground_switch(neg_array_ground_switch),
      .array_sample(array_sample),
      .dac_trial(dac_trial),
      .analog_power_up(analog_power_up),
      .conv_busy(conv_busy),
      .conv_done(conv_done),
      .result_code(result_code),
      .start_ignored(start_ignored)
   );
   sarc_cmp_model sarc_cmp_model_inst (
      .clk(clk),
      .array_sample(array_sample),
      .dac_trial(dac_trial),
      .vin(vin),
      .comp_keep(comp_keep)
   );
   task chk(string nm, logic [13:0] e, g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask
   task conv(int v, v2, logic [13:0] e, bit tog);
      int n;
      logic ig;
      n = 0;
      ig = 0;
      @(posedge clk);
      vin <= v;
      convert_start <= 1;
      while (n < 60 && conv_done !== 1) begin
         @(posedge clk);
         if (n == 8) vin <= v2;
         if (tog && n == 8) convert_start <= 0;
         if (n == 12) convert_start <= 1;
         #1;
         n++;
         ig |= start_ignored;
      end
      chk("result", e, result_code);
      // two cycles of sync, one each for open and disconnect, fourteen steps, then two for the done state and pulse
      chk("cycles", 14'(6 + 14 * `SARC_STEP_CYC), 14'(n));
      chk("ignored", 14'(tog), 14'(ig));
      @(posedge clk);
      convert_start <= 0;
   endtask
   task t_codes;
      foreach (lv[i]) conv(lv[i], lv[i], 14'(lv[i]), 0);
   endtask
   task t_sat;
      conv(20000, 20000, 14'h3fff, 0);
      conv(-7, -7, 14'h0000, 0);
   endtask
   task t_hold;
      conv(100, 9000, 14'h0064, 0);
   endtask
   task t_retrig;
      conv(5000, 5000, 14'h1388, 1);
   endtask
   task t_idle;
      repeat (5) @(posedge clk);
      #1;
      chk("held", 14'h1388, result_code);
      chk("power", 14'h0, 14'(analog_power_up));
   endtask
   task wrap_up;
      if (bad_count == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #(40 * 3000);
      bad_count++;
      wrap_up;
   end
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 0;
      t_codes;
      t_sat;
      t_hold;
      t_retrig;
      t_idle;
      wrap_up;
   end
endmodule
